//--- bit_sync.sv
// Purpose: two flip-flop synchroniser for a group of level signals
// Assumes: each bit is a level or a toggle, never a word
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two stages to settle a metastable first sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : bit_sync
`default_nettype wire

//--- host_bfm.sv
// Purpose: behavioural bus master facing the sensor serial target
// Assumes: the bench resolves the data wire with a pull-up
// Notes:   one phase is Q ref clocks; clock low spans two phases
`timescale 1ns/1ps
`default_nettype none
module host_bfm #(
  parameter int Q = 85
) (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull
);
  // idle bus: both lines released high
  initial begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
  end
  // one phase; Q keeps each level well above the link sampling
  task automatic phase();
    repeat (Q) @(posedge clk);
  endtask : phase
  // start, also usable as a repeated start from clock low
  task automatic start_c();
    sda_pull <= 1'b0;
    phase();
    scl_out <= 1'b1;
    phase();
    sda_pull <= 1'b1;
    phase();
    scl_out <= 1'b0;
    phase();
  endtask : start_c
  // stop, then a bus-free gap
  task automatic stop_c();
    sda_pull <= 1'b1;
    phase();
    scl_out <= 1'b1;
    phase();
    sda_pull <= 1'b0;
    phase();
    phase();
  endtask : stop_c
  // eight bits msb first, then the ninth clock for acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    logic [8:0] bits;
    logic [8:0] got;
    bits = {tx, ack_tx};
    for (int i = 8; i >= 0; i--) begin
      sda_pull <= !bits[i];
      phase();
      scl_out <= 1'b1;
      phase();
      got[i] = sda_in;
      phase();
      scl_out <= 1'b0;
      phase();
    end
    rx     = got[8:1];
    ack_rx = got[0];
  endtask : xfer
endmodule : host_bfm
`default_nettype wire

//--- reg_xfer_if.sv
// Purpose: carries register writes and read requests across clock domains
// Assumes: toggles are sampled through two flip-flops on the far side
// Notes:   data words stay still while their toggle crosses
`timescale 1ns/1ps
`default_nettype none
interface reg_xfer_if;
  logic        wr_tgl;
  logic [1:0]  wr_ptr;
  logic [15:0] wr_data;
  logic        rd_req_tgl;
  logic [1:0]  rd_ptr;
  logic        rd_ack_tgl;
  logic [15:0] rd_data;

  // serial engine side, on the link clock
  modport link (
    output wr_tgl,
    output wr_ptr,
    output wr_data,
    output rd_req_tgl,
    output rd_ptr,
    input  rd_ack_tgl,
    input  rd_data
  );

  // register side, on the reference clock
  modport bank (
    input  wr_tgl,
    input  wr_ptr,
    input  wr_data,
    input  rd_req_tgl,
    input  rd_ptr,
    output rd_ack_tgl,
    output rd_data
  );
endinterface : reg_xfer_if
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench of the sensor serial target
// Assumes: straps at 3'h5 but for one retarget step; host owns the clock
// Notes:   pointer, acknowledge, restart and alert paths are exercised
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] ADDR  = {tsense_pkg::ADDR_FIXED, STRAP};
  logic        ref_clk;
  logic        link_clk;
  logic        arst_n;
  logic        scl;
  logic        host_pull;
  logic        sda_oe;
  logic [15:0] temp_in;
  logic [7:0]  config_out;
  logic        alert_oe;
  logic [2:0]  strap;
  int          failures;
  int          compares;
  // open-drain data wire with pull-up
  wire         sda_line = !(host_pull || sda_oe);
  tsense_i2c_target u_tsense_i2c_target (
    .ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .addr_strap_hi(strap[2]), .addr_strap_mid(strap[1]),
    .addr_strap_lo(strap[0]), .temp_in(temp_in),
    .config_out(config_out), .alert_out(), .alert_oe(alert_oe));
  host_bfm u_host_bfm (
    .clk(ref_clk), .sda_in(sda_line), .scl_out(scl), .sda_pull(host_pull));
  // clocks; the link clock has a phase of its own
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  // master writes a byte; acknowledge 0 means taken
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    u_host_bfm.xfer(b, 1'b1, rx, ack);
    chk_bit(ack, exp_ack);
  endtask : send
  // master reads a byte; last=1 answers with not-acknowledge
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    u_host_bfm.xfer(8'hff, last, rx, ack);
    chk_byte(rx, exp);
  endtask : recv
  // pointer, then restart straight into a read of hysteresis
  task automatic t_restart_hyst();
    u_host_bfm.start_c();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h02, 1'b0);
    u_host_bfm.start_c();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, 8'h7f);
    recv(1'b1, 8'h00);
    u_host_bfm.stop_c();
  endtask : t_restart_hyst
  // limit written msb first, masked, then read with retained pointer
  task automatic t_limit_rw();
    u_host_bfm.start_c();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h03, 1'b0);
    send(8'h12, 1'b0);
    send(8'hb4, 1'b0);
    u_host_bfm.stop_c();
    u_host_bfm.start_c();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, 8'h12);
    recv(1'b1, 8'h80);
    chk_bit(sda_oe, 1'b0);
    u_host_bfm.stop_c();
  endtask : t_limit_rw
  // config takes one byte; an extra byte is acked and dropped
  task automatic t_config();
    u_host_bfm.start_c();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h01, 1'b0);
    send(8'ha5, 1'b0);
    send(8'h5a, 1'b0);
    u_host_bfm.stop_c();
    chk_byte(config_out, 8'ha5);
    u_host_bfm.start_c();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b1, 8'ha5);
    u_host_bfm.stop_c();
  endtask : t_config
  // wrong strap bits and wrong fixed bits both go unanswered
  task automatic t_addr_miss();
    u_host_bfm.start_c();
    send({tsense_pkg::ADDR_FIXED, 3'h4, 1'b0}, 1'b1);
    u_host_bfm.stop_c();
    u_host_bfm.start_c();
    send({4'h1, STRAP, 1'b1}, 1'b1);
    u_host_bfm.stop_c();
    // restrapped pins move the address; the start phases cover the sync
    strap <= 3'h4;
    u_host_bfm.start_c();
    send({tsense_pkg::ADDR_FIXED, 3'h4, 1'b0}, 1'b0);
    u_host_bfm.stop_c();
    strap <= STRAP;
  endtask : t_addr_miss
  // alert sets above the limit, clears below hysteresis; temp read
  task automatic t_temp_alert();
    temp_in <= 16'h7fff;
    repeat (4) @(posedge ref_clk);
    chk_bit(alert_oe, 1'b1);
    temp_in <= 16'h1230;
    repeat (4) @(posedge ref_clk);
    chk_bit(alert_oe, 1'b0);
    u_host_bfm.start_c();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    u_host_bfm.stop_c();
    u_host_bfm.start_c();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, 8'h12);
    recv(1'b1, 8'h30);
    u_host_bfm.stop_c();
  endtask : t_temp_alert
  task automatic tally_and_finish();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // reset long enough for the link domain, then idle before traffic
  initial begin
    arst_n   = 1'b0;
    temp_in  = 16'h1230;
    strap    = STRAP;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge link_clk);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge link_clk);
    @(posedge ref_clk);
    chk_bit(alert_oe, 1'b0);
    t_restart_hyst();
    t_limit_rw();
    t_config();
    t_addr_miss();
    t_temp_alert();
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

//--- tsense_checker_assertions.sv
// Purpose: port checks of the sensor serial target
// Assumes: sda_in is the resolved data wire with a pull-up
// Notes:   sees only top ports; alert is judged on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tsense_checker (
  // clocks and reset
  input wire logic        ref_clk,
  input wire logic        link_clk,
  input wire logic        arst_n,
  // serial pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // sensor side
  input wire logic [15:0] temp_in,
  input wire logic        alert_out,
  input wire logic        alert_oe
);
  // drive moves only in the low half, shortly after a clock fall
  a_oe_scl_low: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $changed(sda_oe) |-> !scl_in) else $error("drive moved, clock high");
  a_oe_after_fall: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $rose(sda_oe) |-> $past(scl_in, 8)) else $error("drive not from clock");
  // an acknowledge outlives the falling edge of its slot
  a_ack_hold: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $fell(scl_in) && sda_oe |=> sda_oe) else $error("ack dropped early");
  // start and stop leave the line released
  a_start_quiet: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    scl_in && $fell(sda_in) |-> ##4 !sda_oe [*8]) else $error("drive at start");
  a_stop_quiet: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    scl_in && $rose(sda_in) |-> !sda_oe [*8]) else $error("drive after stop");
  a_reset_quiet: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    $rose(arst_n) |-> !sda_oe [*4]) else $error("drive after reset");
  // open-drain pins never drive high; top value always trips alert
  a_pins_low: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    sda_out == 1'b0 && alert_out == 1'b0) else $error("pin driven high");
  a_alert_over: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $signed(temp_in) > $signed(16'h7f80) |=> alert_oe) else $error("no alert");
  // main scenarios
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
  c_stop: cover property (@(posedge link_clk) scl_in && $rose(sda_in));
  c_alert: cover property (@(posedge ref_clk) $rose(alert_oe));
endmodule : tsense_checker
bind tsense_i2c_target tsense_checker u_tsense_checker (
  .ref_clk  (ref_clk),
  .link_clk (link_clk),
  .arst_n   (arst_n),
  .scl_in   (scl_in),
  .sda_in   (sda_in),
  .sda_out  (sda_out),
  .sda_oe   (sda_oe),
  .temp_in  (temp_in),
  .alert_out(alert_out),
  .alert_oe (alert_oe)
);
`default_nettype wire

//--- tsense_i2c_target.sv
// Purpose: two-wire serial target of a temperature sensor, top level
// Assumes: link_clk oversamples the serial lines and runs freely
// Notes:   serial engine on link_clk, registers on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tsense_i2c_target (
  // reference clock domain
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // link sampling clock
  input  wire logic        link_clk,
  // serial bus pins, open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // address straps
  input  wire logic        addr_strap_hi,
  input  wire logic        addr_strap_mid,
  input  wire logic        addr_strap_lo,
  // sensor side
  input  wire logic [15:0] temp_in,
  output logic      [7:0]  config_out,
  // alert pin, open drain
  output logic             alert_out,
  output logic             alert_oe
);

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } link_state_e;

  reg_xfer_if xfer ();

  logic [1:0]  lrst_r;
  logic        link_rst_n;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d_r;
  logic        sda_d_r;
  logic [2:0]  strap_s;
  logic [6:0]  own_addr;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  link_state_e state_r;
  logic [2:0]  bit_cnt_r;
  logic        full_r;
  logic [7:0]  shift_r;
  logic        drive_low_r;
  logic        rw_r;
  logic        ack_seen_r;
  logic [7:0]  tx_shift_r;
  logic        tx_left_r;
  logic        addr_match;
  logic        byte_in;
  logic        rx_byte_done;
  logic        addr_rd_hit;
  logic [1:0]  byte_idx_r;
  logic [1:0]  ptr_r;
  logic [7:0]  wr_msb_r;
  logic [15:0] wr_data_r;
  logic        wr_tgl_r;
  logic        rd_req_tgl_r;
  logic        rd_ack_s;
  logic        rd_ack_d_r;
  logic [15:0] tx_word_r;
  logic        tx_wide;
  logic [7:0]  tx_first;
  logic        alert_r;

  // link reset: asserts with arst_n, releases on link_clk
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) lrst_r <= 2'h0;
    else         lrst_r <= {lrst_r[0], 1'b1};
  end
  assign link_rst_n = lrst_r[1];

  // serial lines settle at high, the idle level of the bus
  bit_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     ({scl_in, sda_in}),
    .q     ({scl_s, sda_s})
  );

  // straps are pins too, so they are synchronised before use
  bit_sync #(.W(3), .INIT(3'h0)) u_strap_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     ({addr_strap_hi, addr_strap_mid, addr_strap_lo}),
    .q     (strap_s)
  );

  // read acknowledge toggle coming back from the register side
  bit_sync #(.W(1), .INIT(1'h0)) u_ack_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (xfer.rd_ack_tgl),
    .q     (rd_ack_s)
  );

  // previous samples of the synced lines for edge detection
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // bus conditions, all referred to the host clock line
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;

  // fixed nibble plus straps form the target address
  assign own_addr   = {tsense_pkg::ADDR_FIXED, strap_s};
  assign addr_match = (shift_r[7:1] == own_addr);
  assign byte_in    = scl_fall & full_r;
  assign rx_byte_done = (state_r == ST_RX) & byte_in;
  assign addr_rd_hit  = (state_r == ST_ADDR) & byte_in & addr_match
                        & shift_r[0];

  // the config register is one byte wide, the rest are two
  assign tx_wide  = (ptr_r != tsense_pkg::PTR_CONFIG);
  assign tx_first = tx_wide ? tx_word_r[15:8] : tx_word_r[7:0];

  // main serial engine; stop and start override any state
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= 3'h0;
      full_r      <= 1'b0;
      shift_r     <= 8'h00;
      drive_low_r <= 1'b0;
      rw_r        <= 1'b0;
      ack_seen_r  <= 1'b0;
      tx_shift_r  <= 8'h00;
      tx_left_r   <= 1'b0;
    end else if (stop_det) begin
      state_r     <= ST_IDLE;
      drive_low_r <= 1'b0;
      full_r      <= 1'b0;
    end else if (start_det) begin
      state_r     <= ST_ADDR;
      bit_cnt_r   <= 3'h0;
      full_r      <= 1'b0;
      drive_low_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            // sample on the rising edge while the sender holds data
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == tsense_pkg::LAST_BIT) full_r <= 1'b1;
          end else if (byte_in) begin
            full_r <= 1'b0;
            if (state_r == ST_RX) begin
              drive_low_r <= 1'b1;
              state_r     <= ST_RX_ACK;
            end else if (addr_match) begin
              drive_low_r <= 1'b1;
              rw_r        <= shift_r[0];
              state_r     <= ST_ADDR_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          // acknowledge held through the whole ninth clock period
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            if (rw_r) begin
              tx_shift_r  <= tx_first;
              drive_low_r <= ~tx_first[7];
              tx_left_r   <= tx_wide;
              state_r     <= ST_TX;
            end else begin
              drive_low_r <= 1'b0;
              state_r     <= ST_RX;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            drive_low_r <= 1'b0;
            state_r     <= ST_RX;
          end
        end
        ST_TX: begin
          // data moves only after a falling clock edge
          if (scl_fall) begin
            if (bit_cnt_r == tsense_pkg::LAST_BIT) begin
              drive_low_r <= 1'b0;
              state_r     <= ST_TX_ACK;
            end else begin
              bit_cnt_r   <= bit_cnt_r + 3'h1;
              tx_shift_r  <= {tx_shift_r[6:0], 1'b0};
              drive_low_r <= ~tx_shift_r[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_seen_r <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_seen_r && tx_left_r) begin
              tx_shift_r  <= tx_word_r[7:0];
              drive_low_r <= ~tx_word_r[7];
              tx_left_r   <= 1'b0;
              bit_cnt_r   <= 3'h0;
              state_r     <= ST_TX;
            end else begin
              // no auto-advance, and a not-acknowledge ends the data
              drive_low_r <= 1'b0;
              state_r     <= ST_IDLE;
            end
          end
        end
        default: begin
          // idle: line released, bits ignored until a start
          drive_low_r <= 1'b0;
          state_r     <= ST_IDLE;
        end
      endcase
    end
  end

  // write bytes: pointer first, then MSB and LSB of the register, or one byte for config
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      byte_idx_r <= tsense_pkg::BYTE_PTR;
      ptr_r      <= tsense_pkg::PTR_TEMP;
      wr_msb_r   <= 8'h00;
      wr_data_r  <= 16'h0000;
      wr_tgl_r   <= 1'b0;
    end else if (start_det) begin
      byte_idx_r <= tsense_pkg::BYTE_PTR;
    end else if (rx_byte_done) begin
      case (byte_idx_r)
        tsense_pkg::BYTE_PTR: begin
          // upper six bits should be zero; only the low two select
          ptr_r      <= shift_r[1:0];
          byte_idx_r <= tsense_pkg::BYTE_FIRST;
        end
        tsense_pkg::BYTE_FIRST: begin
          if (ptr_r == tsense_pkg::PTR_CONFIG) begin
            wr_data_r  <= {8'h00, shift_r};
            wr_tgl_r   <= ~wr_tgl_r;
            byte_idx_r <= tsense_pkg::BYTE_EXTRA;
          end else begin
            wr_msb_r   <= shift_r;
            byte_idx_r <= tsense_pkg::BYTE_SECOND;
          end
        end
        tsense_pkg::BYTE_SECOND: begin
          wr_data_r  <= {wr_msb_r, shift_r};
          wr_tgl_r   <= ~wr_tgl_r;
          byte_idx_r <= tsense_pkg::BYTE_EXTRA;
        end
        default: begin
          // later bytes are acknowledged but never reach a register
          byte_idx_r <= tsense_pkg::BYTE_EXTRA;
        end
      endcase
    end
  end

  // read request at address match, answer captured on ack toggle
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_req_tgl_r <= 1'b0;
      rd_ack_d_r   <= 1'b0;
      tx_word_r    <= 16'h0000;
    end else begin
      rd_ack_d_r <= rd_ack_s;
      if (addr_rd_hit) rd_req_tgl_r <= ~rd_req_tgl_r;
      if (rd_ack_s ^ rd_ack_d_r) tx_word_r <= xfer.rd_data;
    end
  end

  // crossing words stay still while their toggles travel
  assign xfer.wr_tgl     = wr_tgl_r;
  assign xfer.wr_ptr     = ptr_r;
  assign xfer.wr_data    = wr_data_r;
  assign xfer.rd_req_tgl = rd_req_tgl_r;
  assign xfer.rd_ptr     = ptr_r;

  tsense_regs u_regs (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .xfer       (xfer.bank),
    .temp_in    (temp_in),
    .config_out (config_out),
    .alert_r    (alert_r)
  );

  // open drain: only ever pull low, enable marks the drive
  assign sda_out   = 1'b0;
  assign sda_oe    = drive_low_r;
  assign alert_out = 1'b0;
  assign alert_oe  = alert_r;

endmodule : tsense_i2c_target
`default_nettype wire

//--- tsense_pkg.sv
// Purpose: shared constants of the temperature sensor serial target
// Assumes: register contents beyond the pointer map live in the ref domain
// Notes:   address nibble, pointer values, register reset values, mask and byte indices are named here once
package tsense_pkg;

  // fixed upper nibble of the seven-bit target address
  localparam logic [3:0]  ADDR_FIXED     = 4'h9;

  // register pointer values (two low bits of the pointer byte)
  localparam logic [1:0]  PTR_TEMP       = 2'h0;
  localparam logic [1:0]  PTR_CONFIG     = 2'h1;
  localparam logic [1:0]  PTR_HYST       = 2'h2;
  localparam logic [1:0]  PTR_LIMIT      = 2'h3;

  // reset values of the writable registers
  localparam logic [7:0]  CONFIG_RST     = 8'h00;
  localparam logic [15:0] HYST_RST       = 16'h7f00;
  localparam logic [15:0] LIMIT_RST      = 16'h7f80;

  // limit and hysteresis keep only sign, integer and half-degree bits
  localparam logic [15:0] LIMIT_MASK     = 16'hff80;

  // byte indices inside a write transfer
  localparam logic [1:0]  BYTE_PTR       = 2'h0;
  localparam logic [1:0]  BYTE_FIRST     = 2'h1;
  localparam logic [1:0]  BYTE_SECOND    = 2'h2;
  localparam logic [1:0]  BYTE_EXTRA     = 2'h3;

  // bits per byte on the serial line, counted from zero
  localparam logic [2:0]  LAST_BIT       = 3'h7;

endpackage : tsense_pkg

//--- tsense_regs.sv
// Purpose: sensor registers and alert comparator in the reference domain
// Assumes: temp_in is synchronous to ref_clk
// Notes:   alert follows limit and hysteresis as a comparator
`timescale 1ns/1ps
`default_nettype none
module tsense_regs (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // crossing from the serial engine
  reg_xfer_if.bank         xfer,
  // sensor side
  input  wire logic [15:0] temp_in,
  output logic      [7:0]  config_out,
  output logic             alert_r
);
  logic [1:0]  tgl_s;
  logic [1:0]  tgl_d_r;
  logic [15:0] hyst_r;
  logic [15:0] limit_r;
  logic        wr_ev;
  logic        rd_ev;

  bit_sync #(.W(2), .INIT(2'h0)) u_tgl_sync (
    .clk   (ref_clk),
    .rst_n (arst_n),
    .d     ({xfer.rd_req_tgl, xfer.wr_tgl}),
    .q     (tgl_s)
  );

  // an edge on either synced toggle is one event
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) tgl_d_r <= 2'h0;
    else         tgl_d_r <= tgl_s;
  end
  assign wr_ev = tgl_s[0] ^ tgl_d_r[0];
  assign rd_ev = tgl_s[1] ^ tgl_d_r[1];

  // writes to the temperature register are dropped, it is read-only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_out <= tsense_pkg::CONFIG_RST;
      hyst_r     <= tsense_pkg::HYST_RST;
      limit_r    <= tsense_pkg::LIMIT_RST;
    end else if (wr_ev) begin
      case (xfer.wr_ptr)
        tsense_pkg::PTR_CONFIG: config_out <= xfer.wr_data[7:0];
        tsense_pkg::PTR_HYST:   hyst_r  <= xfer.wr_data & tsense_pkg::LIMIT_MASK;
        tsense_pkg::PTR_LIMIT:  limit_r <= xfer.wr_data & tsense_pkg::LIMIT_MASK;
        default: ;
      endcase
    end
  end

  // snapshot of the selected register, then acknowledge by toggle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xfer.rd_data    <= 16'h0000;
      xfer.rd_ack_tgl <= 1'b0;
    end else if (rd_ev) begin
      xfer.rd_ack_tgl <= ~xfer.rd_ack_tgl;
      case (xfer.rd_ptr)
        tsense_pkg::PTR_TEMP:   xfer.rd_data <= temp_in;
        tsense_pkg::PTR_CONFIG: xfer.rd_data <= {8'h00, config_out};
        tsense_pkg::PTR_HYST:   xfer.rd_data <= hyst_r;
        default:                xfer.rd_data <= limit_r;
      endcase
    end
  end

  // comparator with hysteresis so the alert does not chatter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) alert_r <= 1'b0;
    else if ($signed(temp_in) > $signed(limit_r)) alert_r <= 1'b1;
    else if ($signed(temp_in) < $signed(hyst_r))  alert_r <= 1'b0;
  end
endmodule : tsense_regs
`default_nettype wire
